// File: rsl_strap_latch.sv
//------------------------------------------------------------------------------
// Purpose: sample configuration straps after reset and hold decoded defaults
// Assumes: straps steady from before reset release; inputs synchronous
// Notes:   capture happens on the first clock edge after reset_n_in rises
//------------------------------------------------------------------------------
// Behaviour
// - every strap is sampled on the first clock edge after each rise of reset_n_in; reset itself loads defaults.
// - a port 1..6 is disabled only when both its D+ and D- disable straps read high.
// - the non-removable port report follows the latched non-removable strap.
// - charging support per port follows the latched charging-enable strap.
// - the operating mode comes from the three mode straps sampled at reset.
// - the non-removable strap decodes to none, 1, 1-2, 1-3, 1-4 or 1-6 ports.
// - the charging strap decodes to none, 1, 1-2, 1-3, 1-4 or 1-6 ports.
// - disabling a legacy port also disables the superspeed port of that number.
`timescale 1ns/100ps
module rsl_strap_latch
  import rsl_pkg::*;
(
  input  wire logic                  sys_clk_in,
  input  wire logic                  reset_n_in,
  input  wire logic [NUM_PORTS-1:0]  port_dplus_disable_strap_in,
  input  wire logic [NUM_PORTS-1:0]  port_dminus_disable_strap_in,
  input  wire logic [CODE_WIDTH-1:0] nonremovable_count_strap_in,
  input  wire logic [CODE_WIDTH-1:0] charging_enable_strap_in,
  input  wire logic [MODE_WIDTH-1:0] mode_select_strap_in,
  output logic      [NUM_PORTS-1:0]  port_disable_out,
  output logic      [NUM_PORTS-1:0]  superspeed_disable_out,
  output logic      [NUM_PORTS-1:0]  nonremovable_mask_out,
  output logic      [NUM_PORTS-1:0]  charging_mask_out,
  output rsl_count_type              nonremovable_count_out,
  output rsl_count_type              charging_count_out,
  output logic      [MODE_WIDTH-1:0] device_mode_out,
  output logic                       config_valid_out
);

  //----------------------------------------------------------------------------
  // capture sequencing
  //----------------------------------------------------------------------------
  typedef enum logic [0:0] {
    RSL_ST_SAMPLE = 1'b0,
    RSL_ST_HOLD   = 1'b1
  } rsl_state_type;

  rsl_state_type  state;
  rsl_straps_type straps;
  rsl_config_type next_config;
  rsl_config_type config_q;
  logic           capture;
  logic [5:0]     nonrem_mask;
  logic [5:0]     charge_mask;
  rsl_count_type  nonrem_count;
  rsl_count_type  charge_count;
  logic [NUM_PORTS-1:0] both_high;

  // reset holds the state at sample; first edge after release captures
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state <= RSL_ST_SAMPLE;
    end else begin
      case (state)
        RSL_ST_SAMPLE: state <= RSL_ST_HOLD;
        RSL_ST_HOLD:   state <= RSL_ST_HOLD;
        default:       state <= RSL_ST_SAMPLE;
      endcase
    end
  end

  assign capture = (state == RSL_ST_SAMPLE);

  //----------------------------------------------------------------------------
  // decode
  //----------------------------------------------------------------------------
  always_comb begin
    straps.dplus_disable  = port_dplus_disable_strap_in;
    straps.dminus_disable = port_dminus_disable_strap_in;
    straps.nonremovable   = rsl_count_type'(nonremovable_count_strap_in);
    straps.charging       = rsl_count_type'(charging_enable_strap_in);
    straps.mode           = mode_select_strap_in;
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PORTS; gi++) begin : g_port
      assign both_high[gi] = straps.dplus_disable[gi] & straps.dminus_disable[gi];
    end
  endgenerate

  rsl_count_decode u_nonrem_decode (
    .code_in   (straps.nonremovable),
    .mask_out  (nonrem_mask),
    .count_out (nonrem_count)
  );

  rsl_count_decode u_charge_decode (
    .code_in   (straps.charging),
    .mask_out  (charge_mask),
    .count_out (charge_count)
  );

  always_comb begin
    next_config.port_disable       = both_high;
    next_config.superspeed_disable = both_high;
    next_config.nonremovable_mask  = nonrem_mask;
    next_config.charging_mask      = charge_mask;
    next_config.nonremovable_count = nonrem_count;
    next_config.charging_count     = charge_count;
    next_config.device_mode        = straps.mode;
  end

  //----------------------------------------------------------------------------
  // held configuration
  //----------------------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_q.port_disable       <= RST_PORT_DIS;
      config_q.superspeed_disable <= RST_PORT_DIS;
      config_q.nonremovable_mask  <= RST_MASK;
      config_q.charging_mask      <= RST_MASK;
      config_q.nonremovable_count <= RSL_CNT_NONE;
      config_q.charging_count     <= RSL_CNT_NONE;
      config_q.device_mode        <= RST_MODE;
    end else if (capture) begin
      config_q <= next_config;
    end
  end

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      config_valid_out <= 1'b0;
    end else begin
      config_valid_out <= capture | config_valid_out;
    end
  end

  assign port_disable_out       = config_q.port_disable;
  assign superspeed_disable_out = config_q.superspeed_disable;
  assign nonremovable_mask_out  = config_q.nonremovable_mask;
  assign charging_mask_out      = config_q.charging_mask;
  assign nonremovable_count_out = config_q.nonremovable_count;
  assign charging_count_out     = config_q.charging_count;
  assign device_mode_out        = config_q.device_mode;

  //----------------------------------------------------------------------------
  // checks
  //----------------------------------------------------------------------------
  // reset_n_in in an antecedent is its sampled level: a release that lands on
  // the clock edge itself must not open a capture check one edge early
  a_capture_once: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    $rose(config_valid_out) |-> $past(state == RSL_ST_SAMPLE) && state == RSL_ST_HOLD)
    else $error("capture did not happen exactly once after reset");

  a_valid_first_edge: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && !config_valid_out |=> config_valid_out)
    else $error("configuration not valid one edge after reset release");

  a_port_disable_and: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && capture |=> port_disable_out ==
      $past(port_dplus_disable_strap_in & port_dminus_disable_strap_in))
    else $error("port disable is not the and of both straps");

  a_nonrem_latched: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && capture && nonremovable_count_strap_in == RSL_CNT_P1_6
      |=> nonremovable_mask_out == MASK_P1_6 && nonremovable_count_out == RSL_CNT_P1_6)
    else $error("non-removable setting not taken from strap");

  a_charge_latched: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && capture && charging_enable_strap_in == RSL_CNT_P1_2
      |=> charging_mask_out == MASK_P1_2 && charging_count_out == RSL_CNT_P1_2)
    else $error("charging setting not taken from strap");

  a_mode_latched: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && capture |=> device_mode_out == $past(mode_select_strap_in))
    else $error("device mode not taken from straps");

  a_nonrem_thermo: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    config_valid_out |-> nonremovable_mask_out ==
      (nonremovable_count_out == RSL_CNT_P1   ? MASK_P1   :
       nonremovable_count_out == RSL_CNT_P1_2 ? MASK_P1_2 :
       nonremovable_count_out == RSL_CNT_P1_3 ? MASK_P1_3 :
       nonremovable_count_out == RSL_CNT_P1_4 ? MASK_P1_4 :
       nonremovable_count_out == RSL_CNT_P1_6 ? MASK_P1_6 : MASK_NONE))
    else $error("non-removable mask outside the six settings");

  a_nonrem_reserved: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && capture && nonremovable_count_strap_in > RSL_CNT_P1_6
      |=> nonremovable_count_out == RSL_CNT_NONE && nonremovable_mask_out == MASK_NONE)
    else $error("reserved non-removable code not taken as all removable");

  a_charge_pairs: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    config_valid_out |-> charging_mask_out ==
      (charging_count_out == RSL_CNT_P1   ? MASK_P1   :
       charging_count_out == RSL_CNT_P1_2 ? MASK_P1_2 :
       charging_count_out == RSL_CNT_P1_3 ? MASK_P1_3 :
       charging_count_out == RSL_CNT_P1_4 ? MASK_P1_4 :
       charging_count_out == RSL_CNT_P1_6 ? MASK_P1_6 : MASK_NONE))
    else $error("charging mask does not match the charging setting");

  a_charge_reserved: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && capture && charging_enable_strap_in > RSL_CNT_P1_6
      |=> charging_count_out == RSL_CNT_NONE && charging_mask_out == MASK_NONE)
    else $error("reserved charging code not taken as no charging port");

  a_charge_thermo: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    reset_n_in && capture && charging_enable_strap_in == RSL_CNT_P1_4
      |=> charging_mask_out == MASK_P1_4 ##1 charging_mask_out == MASK_P1_4)
    else $error("charging mask wrong for ports 1-4 setting");

  a_ss_follows: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    config_valid_out |-> superspeed_disable_out == port_disable_out)
    else $error("superspeed disable differs from legacy disable");

  a_hold_stable: assert property (
    @(posedge sys_clk_in) disable iff (!reset_n_in)
    config_valid_out |=> $stable(port_disable_out) && $stable(device_mode_out)
      && $stable(nonremovable_mask_out) && $stable(charging_mask_out))
    else $error("latched configuration changed between resets");

endmodule

// File: rsl_pkg.sv
//------------------------------------------------------------------------------
// Purpose: shared constants and types of the reset strap latch
// Assumes: strap level detectors deliver a binary code per resistor strap
// Notes:   codes follow the order of the six resistor settings
//------------------------------------------------------------------------------
package rsl_pkg;

  localparam int unsigned NUM_PORTS   = 6;
  localparam int unsigned CODE_WIDTH  = 3;
  localparam int unsigned MODE_WIDTH  = 3;

  // resistor setting codes, weakest pull-down first
  typedef enum logic [2:0] {
    RSL_CNT_NONE    = 3'h0,
    RSL_CNT_P1      = 3'h1,
    RSL_CNT_P1_2    = 3'h2,
    RSL_CNT_P1_3    = 3'h3,
    RSL_CNT_P1_4    = 3'h4,
    RSL_CNT_P1_6    = 3'h5
  } rsl_count_type;

  // per-setting port masks, port 1 in bit 0
  localparam logic [5:0] MASK_NONE  = 6'h00;
  localparam logic [5:0] MASK_P1    = 6'h01;
  localparam logic [5:0] MASK_P1_2  = 6'h03;
  localparam logic [5:0] MASK_P1_3  = 6'h07;
  localparam logic [5:0] MASK_P1_4  = 6'h0f;
  localparam logic [5:0] MASK_P1_6  = 6'h3f;

  // reset values of the held configuration
  localparam logic [5:0] RST_PORT_DIS  = 6'h00;
  localparam logic [5:0] RST_MASK      = 6'h00;
  localparam logic [2:0] RST_MODE      = 3'h0;

  typedef struct packed {
    logic [5:0]    dplus_disable;
    logic [5:0]    dminus_disable;
    rsl_count_type nonremovable;
    rsl_count_type charging;
    logic [2:0]    mode;
  } rsl_straps_type;

  typedef struct packed {
    logic [5:0]    port_disable;
    logic [5:0]    superspeed_disable;
    logic [5:0]    nonremovable_mask;
    logic [5:0]    charging_mask;
    rsl_count_type nonremovable_count;
    rsl_count_type charging_count;
    logic [2:0]    device_mode;
  } rsl_config_type;

endpackage

// File: rsl_count_decode.sv
//------------------------------------------------------------------------------
// Purpose: turn a six-setting strap code into a port mask
// Assumes: code comes from a strap level detector
// Notes:   purely combinational; the caller registers the result
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module rsl_count_decode
  import rsl_pkg::*;
(
  input  wire logic [CODE_WIDTH-1:0] code_in,
  output logic      [5:0]            mask_out,
  output rsl_count_type              count_out
);

  always_comb begin
    case (code_in)
      RSL_CNT_P1: begin
        mask_out  = MASK_P1;
        count_out = RSL_CNT_P1;
      end
      RSL_CNT_P1_2: begin
        mask_out  = MASK_P1_2;
        count_out = RSL_CNT_P1_2;
      end
      RSL_CNT_P1_3: begin
        mask_out  = MASK_P1_3;
        count_out = RSL_CNT_P1_3;
      end
      RSL_CNT_P1_4: begin
        mask_out  = MASK_P1_4;
        count_out = RSL_CNT_P1_4;
      end
      RSL_CNT_P1_6: begin
        mask_out  = MASK_P1_6;
        count_out = RSL_CNT_P1_6;
      end
      // reserved codes fall back to the all-off setting
      default: begin
        mask_out  = MASK_NONE;
        count_out = RSL_CNT_NONE;
      end
    endcase
  end

endmodule

// File: rsl_board_model.sv
//------------------------------------------------------------------------------
// Purpose: board side of the strap latch: strap resistors and reset source
// Assumes: requests from the bench change just after a rising clock edge
// Notes:   once released, busy pins carry other traffic and toggle every cycle
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module rsl_board_model
  import rsl_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           reset_req_n_in,
  input  wire logic           pins_busy_in,
  input  wire rsl_straps_type straps_cfg_in,
  output logic                reset_n_out,
  output rsl_straps_type      straps_out
);
  assign reset_n_out = reset_req_n_in;

  // straps settle while reset is held and stay put through the capture edge
  always_ff @(posedge clk_in) begin
    if (!reset_req_n_in) begin
      straps_out <= straps_cfg_in;
    end else if (pins_busy_in) begin
      straps_out <= rsl_straps_type'(~straps_out);
    end
  end
endmodule

// File: test_rsl_strap_latch.sv
//------------------------------------------------------------------------------
// Purpose: self-checking bench of the reset strap latch
// Assumes: capture on the first clock edge after reset release
// Notes:   eight reset cycles sweep every strap code; pins toggle afterwards in the four odd-numbered cycles
//------------------------------------------------------------------------------
`timescale 1ns/100ps
module test_rsl_strap_latch
  import rsl_pkg::*;
;
  logic                  sys_clk_in = 1'b0;
  logic                  reset_req_n = 1'b0;
  logic                  pins_busy = 1'b0;
  rsl_straps_type        straps_cfg = '0;
  logic                  reset_n;
  rsl_straps_type        straps;
  logic [NUM_PORTS-1:0]  port_dis;
  logic [NUM_PORTS-1:0]  ss_dis;
  logic [NUM_PORTS-1:0]  nr_mask;
  logic [NUM_PORTS-1:0]  ch_mask;
  rsl_count_type         nr_cnt;
  rsl_count_type         ch_cnt;
  logic [MODE_WIDTH-1:0] mode;
  logic                  valid;
  int                    n_errors = 0;
  int                    checked = 0;

  always #5 sys_clk_in = ~sys_clk_in;

  rsl_board_model board (
    .clk_in(sys_clk_in), .reset_req_n_in(reset_req_n), .pins_busy_in(pins_busy),
    .straps_cfg_in(straps_cfg), .reset_n_out(reset_n), .straps_out(straps)
  );

  rsl_strap_latch dut (
    .sys_clk_in(sys_clk_in), .reset_n_in(reset_n),
    .port_dplus_disable_strap_in(straps.dplus_disable),
    .port_dminus_disable_strap_in(straps.dminus_disable),
    .nonremovable_count_strap_in(straps.nonremovable),
    .charging_enable_strap_in(straps.charging),
    .mode_select_strap_in(straps.mode),
    .port_disable_out(port_dis), .superspeed_disable_out(ss_dis),
    .nonremovable_mask_out(nr_mask), .charging_mask_out(ch_mask),
    .nonremovable_count_out(nr_cnt), .charging_count_out(ch_cnt),
    .device_mode_out(mode), .config_valid_out(valid)
  );

  //----------------------------------------------------------------------------
  // expectations and comparisons
  //----------------------------------------------------------------------------
  function automatic logic [5:0] exp_mask(input logic [2:0] c);
    case (c)
      3'h1:    return 6'h01;
      3'h2:    return 6'h03;
      3'h3:    return 6'h07;
      3'h4:    return 6'h0f;
      3'h5:    return 6'h3f;
      default: return 6'h00;
    endcase
  endfunction

  task automatic check_mask(input logic [5:0] got, input logic [5:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_code(input logic [2:0] got, input logic [2:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic verify(input rsl_straps_type s, input logic on);
    logic [5:0] dis;
    logic [2:0] nrc;
    logic [2:0] chc;
    dis = on ? (s.dplus_disable & s.dminus_disable) : 6'h00;
    nrc = (on && s.nonremovable < 3'h6) ? s.nonremovable : 3'h0;
    chc = (on && s.charging < 3'h6) ? s.charging : 3'h0;
    check_mask(port_dis, dis);
    check_mask(ss_dis, dis);
    check_mask(nr_mask, exp_mask(nrc));
    check_mask(ch_mask, exp_mask(chc));
    check_code(nr_cnt, nrc);
    check_code(ch_cnt, chc);
    check_code(mode, on ? s.mode : 3'h0);
    check_code({2'h0, valid}, {2'h0, on});
  endtask

  //----------------------------------------------------------------------------
  // one reset cycle: hold, release, capture, then pins wander if busy is set
  //----------------------------------------------------------------------------
  task automatic run_case(input rsl_straps_type s, input logic busy);
    @(posedge sys_clk_in);
    reset_req_n <= 1'b0;
    straps_cfg  <= s;
    pins_busy   <= busy;
    repeat (5) @(posedge sys_clk_in);
    #1 verify(s, 1'b0);
    @(posedge sys_clk_in);
    reset_req_n <= 1'b1;
    @(posedge sys_clk_in);
    #1 verify(s, 1'b1);
    repeat (5) @(posedge sys_clk_in);
    #1 verify(s, 1'b1);
  endtask

  task automatic complete_run;
    if (n_errors == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    rsl_straps_type s;
    for (int i = 0; i < 8; i++) begin
      s.dplus_disable  = {i[2:0], ~i[2:0]};
      s.dminus_disable = {i[2:0] ^ 3'h5, 3'h7};
      s.nonremovable   = rsl_count_type'(i[2:0]);
      s.charging       = rsl_count_type'(3'h7 - i[2:0]);
      s.mode           = i[2:0];
      run_case(s, i[0]);
    end
    complete_run();
  end

  initial begin
    repeat (1000) @(posedge sys_clk_in);
    n_errors++;
    complete_run();
  end
endmodule
